// ---- hwrnc_pkg.sv ----
// Purpose: Shared constants and types for the hart wait/reset/NMI control
// Assumes: 32-bit machine registers, word-addressed Avalon-MM slave
// Notes:   Register indices are word addresses on the slave port
package hwrnc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices (word address)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_INT_ENABLE = 4'h1;
    localparam logic [3:0] REG_INT_PENDING = 4'h2;
    localparam logic [3:0] REG_EPC = 4'h3;
    localparam logic [3:0] REG_CAUSE = 4'h4;
    localparam logic [3:0] REG_ISA = 4'h5;
    localparam logic [3:0] REG_PMP_CFG = 4'h6;
    localparam logic [3:0] REG_TRAP_VECTOR = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // Control register field positions
    localparam int CTRL_TW_BIT = 0;
    localparam int CTRL_MODIFY_PRIVILEGE_BIT_BIT = 1;
    localparam int CTRL_MIE_BIT = 2;
    localparam int CTRL_MPIE_BIT = 3;
    localparam int CTRL_MPP_LSB = 4;
    localparam int CTRL_WFI_MODE_LSB = 6;
    localparam int CTRL_U_WFI_BIT = 8;
    localparam int CTRL_PRIV_LSB = 16;
    localparam int CTRL_STALLED_BIT = 18;

    ////////////////////////////////////////////////////////////////////////
    // Privilege levels and wait modes
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;
    localparam logic [1:0] WFI_STALL = 2'h0;
    localparam logic [1:0] WFI_NOP = 2'h1;
    localparam logic [1:0] WFI_TRAP = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Cause codes, reset values, masks
    localparam logic [31:0] CAUSE_ILLEGAL = 32'h0000_0002;
    localparam logic [31:0] CAUSE_INT_FLAG = 32'h8000_0000;
    localparam logic [31:0] RESET_CAUSE = 32'h0000_0000;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    localparam logic [31:0] PMP_CLEAR_MASK = 32'h6767_6767;
    localparam logic [31:0] PMP_RESET = 32'h0000_0000;
    localparam logic [15:0] INT_EN_RESET = 16'h0000;
    localparam logic [1:0] MPP_RESET = 2'h0;

    typedef enum logic [1:0] {OP_OTHER, OP_WFI, OP_MRET} hwrnc_op_t;
    typedef enum logic {ST_RUN, ST_WAIT} hwrnc_fsm_t;

    typedef struct packed {
        logic valid;
        hwrnc_op_t op;
        logic [31:0] pc;
    } hwrnc_issue_t;

    typedef struct packed {
        logic retire;
        logic illegal;
        logic redirect;
        logic [31:0] redirect_pc;
    } hwrnc_resp_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } hwrnc_av_req_t;

    typedef struct packed {
        hwrnc_fsm_t fsm;
        logic [1:0] priv;
        logic tw;
        logic modify_privilege_bit;
        logic machine_global_int_enable;
        logic mpie;
        logic [1:0] mpp;
        logic [1:0] wfi_mode;
        logic u_wfi;
        logic [15:0] int_en;
        logic [31:0] epc;
        logic [31:0] cause;
        logic [31:0] physical_memory_protection;
        logic [31:0] tvec;
        logic [31:0] wfi_pc;
        logic [31:0] next_pc;
        hwrnc_resp_t resp;
        logic ack;
        logic [31:0] rdata;
        logic nmi_d;
    } hwrnc_state_t;

endpackage

// ---- hwrnc_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
module hwrnc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [WIDTH-1:0] async_in, // Pin levels
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);

    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end

endmodule

// ---- hwrnc_ctrl.sv ----
// Purpose: Hart control for wait-for-interrupt, reset state and NMI entry
// Assumes: Core offers one instruction at a time on the issue port
// Notes:   Redirect and retire come one cycle after the instruction is taken, or for a stalling WFI one cycle after the wake
module hwrnc_ctrl
    import hwrnc_pkg::*;
#(
    parameter logic [31:0] RESET_VECTOR = 32'h0000_0000,
    parameter logic [31:0] NMI_VECTOR = 32'h0000_0100,
    parameter logic [31:0] TRAP_VECTOR_RESET = 32'h0000_0200,
    parameter logic [31:0] NMI_CAUSE = 32'h0000_0000,
    parameter logic [31:0] ISA_VALUE = 32'h4000_0100
) (
    input wire logic sys_clk, // Core clock, 40 MHz
    input wire logic rst_n, // Async reset, active low
    input wire hwrnc_av_req_t av_req, // Avalon-MM request
    output logic [31:0] av_readdata, // Avalon-MM read data
    output logic av_waitrequest, // Avalon-MM wait
    input wire hwrnc_issue_t issue, // Instruction offered by core
    output logic issue_ready, // Instruction accepted this cycle
    output hwrnc_resp_t resp, // Retire, illegal, redirect
    output logic [31:0] fetch_pc, // Next pc to fetch, sequential or redirect target
    output logic [1:0] priv_mode, // Current privilege
    output logic modify_privilege_bit_out, // Modify-privilege bit
    output logic stalled, // Hart waiting for interrupt
    input wire logic [15:0] int_pending_pin, // Platform interrupt levels
    input wire logic nmi_pin // Platform NMI level
);

    ////////////////////////////////////////////////////////////////////////
    // Reset state

    localparam hwrnc_state_t STATE_RESET = '{
        fsm: ST_RUN, priv: PRIV_M, tw: 1'b0, modify_privilege_bit: 1'b0, machine_global_int_enable: 1'b0,
        mpie: 1'b0, mpp: MPP_RESET, wfi_mode: WFI_STALL, u_wfi: 1'b0,
        int_en: INT_EN_RESET, epc: 32'h0000_0000, cause: RESET_CAUSE,
        physical_memory_protection: PMP_RESET, tvec: TRAP_VECTOR_RESET, wfi_pc: 32'h0000_0000,
        next_pc: RESET_VECTOR,
        resp: '{retire: 1'b0, illegal: 1'b0, redirect: 1'b0,
                redirect_pc: RESET_VECTOR},
        ack: 1'b0, rdata: 32'h0000_0000, nmi_d: 1'b0};

    hwrnc_state_t state_reg;
    hwrnc_state_t state_next;
    logic [15:0] pend_sync;
    logic nmi_sync;
    logic [15:0] pend_en;
    logic wake;
    logic glob_ok;
    logic nmi_evt;
    logic bus_req;
    logic [31:0] int_cause;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    hwrnc_sync #(.WIDTH(17)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({nmi_pin, int_pending_pin}),
        .sync_out({nmi_sync, pend_sync})
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] merge_be(logic [31:0] old_v,
                                             logic [31:0] new_v,
                                             logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] lowest_int(logic [15:0] v);
        logic [31:0] r;
        r = CAUSE_INT_FLAG;
        for (int i = 15; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = CAUSE_INT_FLAG | 32'(i);
            end
        end
        return r;
    endfunction

    function automatic hwrnc_state_t enter_trap(hwrnc_state_t st,
                                                logic [31:0] epc_v,
                                                logic [31:0] cause_v);
        hwrnc_state_t r;
        r = st;
        r.mpie = st.machine_global_int_enable;
        r.machine_global_int_enable = 1'b0;
        r.mpp = st.priv;
        r.priv = PRIV_M;
        r.epc = epc_v;
        r.cause = cause_v;
        r.resp.redirect = 1'b1;
        r.resp.redirect_pc = st.tvec;
        r.next_pc = st.tvec;
        r.fsm = ST_RUN;
        return r;
    endfunction

    function automatic logic [31:0] read_mux(hwrnc_state_t st,
                                             logic [3:0] a,
                                             logic [15:0] pend);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            REG_CTRL:
            begin
                r[CTRL_TW_BIT] = st.tw;
                r[CTRL_MODIFY_PRIVILEGE_BIT_BIT] = st.modify_privilege_bit;
                r[CTRL_MIE_BIT] = st.machine_global_int_enable;
                r[CTRL_MPIE_BIT] = st.mpie;
                r[CTRL_MPP_LSB +: 2] = st.mpp;
                r[CTRL_WFI_MODE_LSB +: 2] = st.wfi_mode;
                r[CTRL_U_WFI_BIT] = st.u_wfi;
                r[CTRL_PRIV_LSB +: 2] = st.priv;
                r[CTRL_STALLED_BIT] = (st.fsm == ST_WAIT);
            end
            REG_INT_ENABLE: r[15:0] = st.int_en;
            REG_INT_PENDING: r[15:0] = pend;
            REG_EPC: r = st.epc;
            REG_CAUSE: r = st.cause;
            // 32-bit width and a single extension bit (bit 8) set
            REG_ISA: r = ISA_VALUE;
            REG_PMP_CFG: r = st.physical_memory_protection;
            REG_TRAP_VECTOR: r = st.tvec;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    assign pend_en = pend_sync & state_reg.int_en;
    assign wake = |pend_en;
    assign glob_ok = (state_reg.priv != PRIV_M) | state_reg.machine_global_int_enable;
    assign nmi_evt = nmi_sync & ~state_reg.nmi_d;
    assign bus_req = av_req.read | av_req.write;
    assign int_cause = lowest_int(pend_en);

    always_comb
    begin
        logic [31:0] wd;
        wd = 32'h0000_0000;
        state_next = state_reg;
        state_next.resp.retire = 1'b0;
        state_next.resp.illegal = 1'b0;
        state_next.resp.redirect = 1'b0;
        state_next.nmi_d = nmi_sync;
        state_next.ack = bus_req & ~state_reg.ack;
        if (bus_req & ~state_reg.ack & av_req.read)
        begin
            state_next.rdata = read_mux(state_reg, av_req.address,
                                        pend_sync);
        end
        if (state_reg.ack & av_req.write)
        begin
            wd = merge_be(read_mux(state_reg, av_req.address, pend_sync),
                          av_req.writedata, av_req.byteenable);
            unique case (av_req.address)
                REG_CTRL:
                begin
                    state_next.tw = wd[CTRL_TW_BIT];
                    state_next.modify_privilege_bit = wd[CTRL_MODIFY_PRIVILEGE_BIT_BIT];
                    state_next.machine_global_int_enable = wd[CTRL_MIE_BIT];
                    state_next.mpie = wd[CTRL_MPIE_BIT];
                    state_next.mpp = wd[CTRL_MPP_LSB +: 2];
                    state_next.wfi_mode = wd[CTRL_WFI_MODE_LSB +: 2];
                    state_next.u_wfi = wd[CTRL_U_WFI_BIT];
                end
                REG_INT_ENABLE: state_next.int_en = wd[15:0];
                REG_EPC: state_next.epc = wd;
                REG_CAUSE: state_next.cause = wd;
                // match and lock fields are writable here
                REG_PMP_CFG: state_next.physical_memory_protection = wd;
                REG_TRAP_VECTOR: state_next.tvec = wd;
                default: state_next.tvec = state_next.tvec;
            endcase
        end
        if (nmi_evt)
        begin
            // vector jump, only pc and cause saved
            if (state_reg.fsm == ST_WAIT)
            begin
                state_next.epc = state_reg.wfi_pc + PC_STEP;
            end
            else if (issue.valid)
            begin
                state_next.epc = issue.pc;
            end
            else
            begin
                state_next.epc = state_reg.next_pc;
            end
            state_next.cause = NMI_CAUSE;
            state_next.priv = PRIV_M;
            state_next.fsm = ST_RUN;
            state_next.resp.redirect = 1'b1;
            state_next.resp.redirect_pc = NMI_VECTOR;
            state_next.next_pc = NMI_VECTOR;
        end
        else if (state_reg.fsm == ST_WAIT)
        begin
            // leave the stall on a sampled wake
            if (wake & glob_ok)
            begin
                state_next = enter_trap(state_next,
                                        state_reg.wfi_pc + PC_STEP,
                                        int_cause);
                state_next.resp.retire = 1'b1;
            end
            else if (wake)
            begin
                state_next.fsm = ST_RUN;
                state_next.resp.retire = 1'b1;
                state_next.resp.redirect = 1'b1;
                state_next.resp.redirect_pc = state_reg.wfi_pc + PC_STEP;
                state_next.next_pc = state_reg.wfi_pc + PC_STEP;
            end
        end
        else if (issue.valid)
        begin
            if (wake & glob_ok)
            begin
                state_next = enter_trap(state_next, issue.pc, int_cause);
            end
            else
            begin
                unique case (issue.op)
                    OP_WFI:
                    begin
                        // illegal only when trapped by control
                        if ((state_reg.tw & (state_reg.priv != PRIV_M)) |
                            ((state_reg.priv == PRIV_U) & ~state_reg.u_wfi))
                        begin
                            state_next = enter_trap(state_next, issue.pc,
                                                    CAUSE_ILLEGAL);
                            state_next.resp.illegal = 1'b1;
                        end
                        else if (state_reg.wfi_mode == WFI_NOP)
                        begin
                            state_next.resp.retire = 1'b1;
                            state_next.next_pc = issue.pc + PC_STEP;
                        end
                        else if (state_reg.wfi_mode == WFI_TRAP)
                        begin
                            state_next = enter_trap(state_next, issue.pc,
                                                    CAUSE_ILLEGAL);
                            state_next.resp.illegal = 1'b1;
                        end
                        else
                        begin
                            state_next.fsm = ST_WAIT;
                            state_next.wfi_pc = issue.pc;
                        end
                    end
                    OP_MRET:
                    begin
                        if (state_reg.priv != PRIV_M)
                        begin
                            state_next = enter_trap(state_next, issue.pc,
                                                    CAUSE_ILLEGAL);
                            state_next.resp.illegal = 1'b1;
                        end
                        else
                        begin
                            state_next.priv = state_reg.mpp;
                            state_next.machine_global_int_enable = state_reg.mpie;
                            state_next.mpie = 1'b1;
                            state_next.mpp = PRIV_U;
                            state_next.resp.retire = 1'b1;
                            state_next.resp.redirect = 1'b1;
                            state_next.resp.redirect_pc = state_reg.epc;
                            state_next.next_pc = state_reg.epc;
                        end
                    end
                    default:
                    begin
                        state_next.resp.retire = 1'b1;
                        state_next.next_pc = issue.pc + PC_STEP;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= STATE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign issue_ready = (state_reg.fsm == ST_RUN) & ~nmi_evt;
    assign av_waitrequest = bus_req & ~state_reg.ack;
    assign av_readdata = state_reg.rdata;
    assign resp = state_reg.resp;
    assign fetch_pc = state_reg.next_pc;
    assign priv_mode = state_reg.priv;
    assign modify_privilege_bit_out = state_reg.modify_privilege_bit;
    assign stalled = (state_reg.fsm == ST_WAIT);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    wait_no_issue_a: assert property (
        stalled |-> !issue_ready && !resp.retire)
        else $error("Stalled hart accepted or retired");

    tw_illegal_a: assert property (
        !nmi_evt && !stalled && issue.valid && issue.op == OP_WFI &&
        state_reg.tw && priv_mode != PRIV_M && !(wake && glob_ok)
        |=> resp.illegal && state_reg.cause == CAUSE_ILLEGAL)
        else $error("Timeout-wait did not raise illegal trap");

    wake_seq_a: assert property (
        stalled && wake && !glob_ok && !nmi_evt
        |=> resp.redirect && resp.retire &&
            resp.redirect_pc == $past(state_reg.wfi_pc) + PC_STEP)
        else $error("Wake did not continue after wait");

    wake_trap_epc_a: assert property (
        stalled && wake && glob_ok && !nmi_evt
        |=> state_reg.epc == $past(state_reg.wfi_pc) + PC_STEP &&
            priv_mode == PRIV_M && resp.redirect)
        else $error("Wake trap saved wrong pc");

    no_wake_a: assert property (
        stalled && !wake && !nmi_evt |=> stalled && !resp.redirect)
        else $error("Hart woke without enabled interrupt");

    nmi_vector_a: assert property (
        nmi_evt |=> resp.redirect && resp.redirect_pc == NMI_VECTOR &&
                    priv_mode == PRIV_M && state_reg.cause == NMI_CAUSE)
        else $error("NMI did not reach its vector");

    nmi_keep_a: assert property (
        nmi_evt |=> state_reg.machine_global_int_enable == $past(state_reg.machine_global_int_enable) &&
                    state_reg.mpp == $past(state_reg.mpp) &&
                    state_reg.int_en == $past(state_reg.int_en))
        else $error("NMI disturbed other state");

    mret_pop_a: assert property (
        !nmi_evt && issue_ready && issue.valid && issue.op == OP_MRET &&
        priv_mode == PRIV_M && !(wake && glob_ok)
        |=> resp.redirect_pc == $past(state_reg.epc) &&
            priv_mode == $past(state_reg.mpp) &&
            state_reg.machine_global_int_enable == $past(state_reg.mpie))
        else $error("Trap return did not pop stack");

    bus_ack_a: assert property (
        bus_req && !state_reg.ack |=> !av_waitrequest ##1 !state_reg.ack)
        else $error("Bus answer not in two cycles");

endmodule

// ---- hwrnc_src_model.sv ----
// Purpose: Platform interrupt and NMI source model
// Assumes: Bench asks for line levels; model drives the pins
// Notes:   Pins change only just after a clock edge
module hwrnc_src_model (
    input wire logic sys_clk, // Core clock
    input wire logic rst_n, // Reset, active low
    input wire logic [15:0] int_req, // Requested interrupt levels
    input wire logic nmi_req, // Requested NMI level
    output logic [15:0] int_pending_pin, // Interrupt lines
    output logic nmi_pin // NMI line
);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_pending_pin <= 16'h0000;
            nmi_pin <= 1'b0;
        end
        else
        begin
            int_pending_pin <= int_req;
            nmi_pin <= nmi_req;
        end
    end
endmodule

// ---- hart_wait_reset_nmi_control_tb_top.sv ----
// Purpose: Self-checking bench for hart wait, reset and NMI control
// Assumes: Machine mode after reset, registers on Avalon-MM
// Notes:   Random pcs and interrupt lines from a fixed seed
module hart_wait_reset_nmi_control_tb_top
    import hwrnc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RV = 32'h0000_1000;
    localparam logic [31:0] NV = 32'h0000_0100;
    localparam logic [31:0] TV = 32'h0000_0200;
    localparam logic [31:0] ISA = 32'h4000_0100;
    localparam logic [31:0] CTL [4] = '{32'h0000_0040, 32'h0000_0080,
        32'h0000_0000, 32'h0000_0101};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    hwrnc_av_req_t av_req = '0;
    hwrnc_issue_t issue = '0;
    hwrnc_resp_t resp;
    logic [31:0] av_readdata, fetch_pc, q, pc, f;
    logic av_waitrequest, issue_ready, modify_privilege_bit_out, stalled, nmi_pin;
    logic nmi_req = 1'b0;
    logic [1:0] priv_mode;
    logic [15:0] int_pending_pin;
    logic [15:0] int_req = 16'h0000;
    int fails = 0;
    int tests_run = 0;
    int seed = 15794;
    int k;

    always #12.5 sys_clk = ~sys_clk;

    hwrnc_ctrl #(.RESET_VECTOR(RV), .NMI_VECTOR(NV), .TRAP_VECTOR_RESET(TV),
        .NMI_CAUSE(32'h0000_0000), .ISA_VALUE(ISA)) i_hwrnc_ctrl (
        .sys_clk(sys_clk), .rst_n(rst_n), .av_req(av_req),
        .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
        .issue(issue), .issue_ready(issue_ready), .resp(resp),
        .fetch_pc(fetch_pc), .priv_mode(priv_mode), .modify_privilege_bit_out(modify_privilege_bit_out),
        .stalled(stalled), .int_pending_pin(int_pending_pin),
        .nmi_pin(nmi_pin));

    hwrnc_src_model i_hwrnc_src_model (.sys_clk(sys_clk), .rst_n(rst_n),
        .int_req(int_req), .nmi_req(nmi_req),
        .int_pending_pin(int_pending_pin), .nmi_pin(nmi_pin));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
    begin
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
            fails++;
        end
    end
    endtask

    // Holds the request until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        int n;
    begin
        n = 0;
        @(posedge sys_clk);
        av_req <= '{~wr, wr, a, 4'hf, d};
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (av_waitrequest !== 1'b0 && n < 50);
        @(posedge sys_clk);
        q = av_readdata;
        av_req <= '0;
        chk(n < 50, 1);
    end
    endtask

    // Ends at the negedge after acceptance, where resp stands
    task automatic iss(input hwrnc_op_t op, input logic [31:0] p);
        int n;
    begin
        n = 0;
        @(posedge sys_clk);
        issue <= '{1'b1, op, p};
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (issue_ready !== 1'b1 && n < 50);
        @(posedge sys_clk);
        issue.valid <= 1'b0;
        @(negedge sys_clk);
        chk(n < 50, 1);
    end
    endtask

    task automatic wait_redir();
        int n;
    begin
        n = 0;
        while (resp.redirect !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk(n < 200, 1);
    end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk(priv_mode, PRIV_M);
        chk(modify_privilege_bit_out, 0);
        chk(fetch_pc, RV);
        bus(0, REG_CTRL, 0);
        chk(q[CTRL_MIE_BIT], 0);
        bus(0, REG_CAUSE, 0);
        chk(q, RESET_CAUSE);
        bus(0, REG_ISA, 0);
        chk(q, ISA);
        bus(0, REG_PMP_CFG, 0);
        chk(q, PMP_RESET);
        bus(0, 4'h9, 0);
        chk(q, 0);
        $display("test reset done");
        for (int m = 0; m < 2; m++)
        begin
            k = {$random(seed)} % 16;
            pc = $random(seed) & 32'hffff_fffc;
            bus(1, REG_INT_ENABLE, 32'h1 << k);
            bus(1, REG_CTRL, 32'(m) << CTRL_MIE_BIT);
            iss(OP_WFI, pc);
            chk(stalled, 1);
            @(posedge sys_clk);
            int_req <= 16'h1 << ((k + 1) % 16);
            repeat (8) @(negedge sys_clk);
            chk(stalled, 1);
            chk(issue_ready, 0);
            @(posedge sys_clk);
            int_req <= 16'h1 << k;
            wait_redir();
            chk(resp.retire, 1);
            chk(resp.redirect_pc, m ? TV : pc + PC_STEP);
            @(posedge sys_clk);
            int_req <= 16'h0000;
            bus(0, REG_EPC, 0);
            if (m == 1)
                chk(q, pc + PC_STEP);
        end
        $display("test wait wake done");
        bus(1, REG_CTRL, 32'h0000_0004);
        @(negedge sys_clk);
        f = fetch_pc;
        @(posedge sys_clk);
        nmi_req <= 1'b1;
        wait_redir();
        chk(resp.redirect_pc, NV);
        bus(0, REG_EPC, 0);
        chk(q, f);
        bus(0, REG_CAUSE, 0);
        chk(q, 0);
        bus(0, REG_CTRL, 0);
        chk(q[CTRL_MIE_BIT], 1);
        nmi_req <= 1'b0;
        $display("test nmi done");
        for (int i = 0; i < 4; i++)
        begin
            pc = $random(seed) & 32'hffff_fffc;
            bus(1, REG_EPC, pc);
            bus(1, REG_CTRL, CTL[i]);
            if (i > 1)
            begin
                iss(OP_MRET, 32'h0000_0000);
                chk(resp.redirect_pc, pc);
                chk(priv_mode, PRIV_U);
            end
            iss(OP_WFI, pc);
            chk(resp.illegal, i != 0);
            chk(stalled, 0);
        end
        $display("test wait modes done");
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        close_out();
    end
endmodule
